// ---- dv/scg_osc_model.sv ----
// far-side model: main and subsystem oscillator tick sources
`timescale 1ns/1ps
module scg_osc_model (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // tick spacing chosen by the bench
  input wire logic [7:0] mainPer,
  input wire logic [7:0] subPer,
  // gating from the block
  input wire logic mainOscEn,
  // tick enables
  output logic mainTick,
  output logic subTick
);
  logic [7:0] mainCnt;
  logic [7:0] subCnt;

  // main oscillator is silent while the block holds it off
  always_ff @(posedge clock) begin
    if (sys_rst || !mainOscEn) begin
      mainCnt <= 8'h00;
      mainTick <= 1'b0;
    end else begin
      mainTick <= (mainCnt == mainPer - 8'h01);
      mainCnt <= (mainCnt == mainPer - 8'h01) ? 8'h00 : mainCnt + 8'h01;
    end
  end

  // subsystem oscillator never stops, in either standby
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      subCnt <= 8'h00;
      subTick <= 1'b0;
    end else begin
      subTick <= (subCnt == subPer - 8'h01);
      subCnt <= (subCnt == subPer - 8'h01) ? 8'h00 : subCnt + 8'h01;
    end
  end
endmodule

// ---- dv/testbench.sv ----
// self-checking bench for the standby clock gating control block
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData;
  logic mainTick;
  logic subTick;
  logic haltCmd = 1'b0;
  logic stopCmd = 1'b0;
  logic masterEnable = 1'b0;
  logic [7:0] irqReq = 8'h00;
  logic cpuTick, resumeNext, resumeVector, mainOscEn, btRun, serialRun;
  logic eventRun, watchRun, dispRun, syncIntRun, asyncIntRun;
  logic intervalFlag, irq;
  logic [7:0] mainPer = 8'h02;
  logic [7:0] subPer = 8'h07;
  logic [7:0] rnd = 8'h44;
  logic [7:0] rdv;
  logic [7:0] gate;
  logic [3:0] per;
  int n_errors = 0;
  int samples_checked = 0;
  int n;
  int b;
  int expN;

  // gating outputs gathered in one vector for comparison
  assign gate = {mainOscEn, btRun, serialRun, eventRun, watchRun, dispRun,
                 syncIntRun, asyncIntRun};

  initial begin
    forever #2.5 clock = ~clock;
  end

  scg_standby_ctrl u_scg_standby_ctrl (
    .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .mainTick(mainTick), .subTick(subTick),
    .haltCmd(haltCmd), .stopCmd(stopCmd), .masterEnable(masterEnable),
    .irqReq(irqReq), .cpuTick(cpuTick), .resumeNext(resumeNext),
    .resumeVector(resumeVector), .mainOscEn(mainOscEn), .btRun(btRun),
    .serialRun(serialRun), .eventRun(eventRun), .watchRun(watchRun),
    .dispRun(dispRun), .syncIntRun(syncIntRun), .asyncIntRun(asyncIntRun),
    .intervalFlag(intervalFlag), .irq(irq)
  );

  scg_osc_model u_scg_osc_model (
    .clock(clock), .sys_rst(sys_rst), .mainPer(mainPer), .subPer(subPer),
    .mainOscEn(mainOscEn), .mainTick(mainTick), .subTick(subTick)
  );

  // reference model: expected gating per mode (0 run, 1 halt, 2 stop)
  function automatic logic [7:0] expGate(input int mode,
                                         input logic [3:0] src);
    case (mode)
      1: expGate = 8'hFD;
      2: expGate = {2'b00, src[0], src[1], src[2], src[3], 2'b01};
      default: expGate = 8'hFF;
    endcase
  endfunction

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task end_of_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clock);
    regWrEn <= 1'b0;
  endtask

  // read data stand in the cycle after the strobe edge only
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clock);
    regRdEn <= 1'b0;
    #1;
    d = regRdData;
  endtask

  task cmd(input logic deep);
    @(posedge clock);
    if (deep) stopCmd <= 1'b1;
    else haltCmd <= 1'b1;
    @(posedge clock);
    stopCmd <= 1'b0;
    haltCmd <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  // cycles between two cpu ticks, bounded
  task period(output int p);
    int k;
    k = 0;
    p = 0;
    #1;
    while (cpuTick !== 1'b1 && k < 2000) begin
      @(posedge clock);
      #1;
      k++;
    end
    do begin
      @(posedge clock);
      #1;
      p++;
    end while (cpuTick !== 1'b1 && p < 2000);
    if (p >= 2000) begin
      n_errors++;
      end_of_test;
    end
  endtask

  // raise one request and follow the release to the resume pulse
  task wake(input int bit_i, input logic me, input int lo, input int hi);
    int k;
    int t;
    k = 0;
    t = 0;
    @(posedge clock);
    irqReq <= 8'h01 << bit_i;
    masterEnable <= me;
    do begin
      @(posedge clock);
      #1;
      k++;
      if (mainTick === 1'b1) t++;
    end while (!(resumeVector === 1'b1 || resumeNext === 1'b1) && k < 20000);
    if (k >= 20000) begin
      n_errors++;
      end_of_test;
    end
    chk("resumeVector", resumeVector, me);
    chk("resumeNext", resumeNext, !me);
    chk("waitTicks", (t >= lo && t <= hi), 1'b1);
    @(posedge clock);
    irqReq <= 8'h00;
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], rdv);
      chk("regReset", rdv, (a == 7) ? 8'h04 : 8'h00);
    end
    chk("gateRun", gate, expGate(0, 4'h0));
    wr(scg_pkg::REG_STATE, 8'hFF);
    rd(scg_pkg::REG_STATE, rdv);
    chk("stateRo", rdv, 8'h04);
    // each divider setting, then the subsystem clock
    for (int s = 0; s < 4; s++) begin
      wr(scg_pkg::REG_CPU_DIV, s[7:0]);
      period(n);
      period(n);
      // main ticks come every second cycle here
      expN = 2 * (s == 0 ? 64 : s == 1 ? 8 : 4);
      chk("cpuPeriod", n[15:0], expN[15:0]);
    end
    wr(scg_pkg::REG_SYS_SRC, 8'h01);
    period(n);
    period(n);
    chk("subPeriod", n[15:0], 16'h001C);
    // light standby on the subsystem clock, left by reset
    cmd(1'b0);
    rd(scg_pkg::REG_STATE, rdv);
    chk("haltOnSub", rdv, 8'h0D);
    n = 0;
    repeat (64) begin
      @(posedge clock);
      #1;
      if (cpuTick !== 1'b0) n++;
    end
    chk("cpuGated", n[15:0], 16'h0000);
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    rd(scg_pkg::REG_STATE, rdv);
    chk("resetRelease", rdv, 8'h04);
    // deep standby refused on the subsystem clock, flagged by interrupt
    wr(scg_pkg::REG_SYS_SRC, 8'h01);
    wr(scg_pkg::REG_MASK, 8'h01);
    cmd(1'b1);
    rd(scg_pkg::REG_STATE, rdv);
    chk("stopRefused", rdv, 8'h0C);
    chk("irqRefused", irq, 1'b1);
    rd(scg_pkg::REG_STATUS, rdv);
    chk("statusRefused", rdv & 8'h01, 8'h01);
    @(posedge clock);
    #1;
    chk("irqCleared", irq, 1'b0);
    // light standby on the main clock, random wake source
    wr(scg_pkg::REG_SYS_SRC, 8'h00);
    wr(scg_pkg::REG_WAIT_SEL, 8'h03);
    rnd = lfsr(rnd);
    b = 1 + int'(rnd % 8'h06);
    wr(scg_pkg::REG_WAKE_EN, 8'h01 << b);
    cmd(1'b0);
    chk("gateHalt", gate, expGate(1, 4'h0));
    @(posedge clock);
    irqReq <= 8'h7E ^ (8'h01 << b);
    repeat (10) @(posedge clock);
    irqReq <= 8'h00;
    rd(scg_pkg::REG_STATE, rdv);
    chk("notEnabled", rdv, 8'h05);
    wake(b, rnd[7], 32, 36);
    rd(scg_pkg::REG_STATUS, rdv);
    chk("statusWake", rdv & 8'h06, 8'h06);
    // deep standby with two peripheral source patterns, watch wake
    for (int p = 0; p < 2; p++) begin
      per = p ? 4'hA : 4'h5;
      wr(scg_pkg::REG_PER_SRC, {4'h0, per});
      wr(scg_pkg::REG_WAKE_EN, 8'h80);
      cmd(1'b1);
      chk("gateStop", gate, expGate(2, per));
      chk("stopOsc", {mainOscEn, btRun}, 2'b00);
      chk("stopWatch", watchRun, per[2]);
      chk("stopAsync", {syncIntRun, asyncIntRun}, 2'b01);
      rnd = lfsr(rnd);
      wake(7, rnd[0], 32, 36);
    end
    // main oscillator parked: light standby, no wait on release
    wr(scg_pkg::REG_SYS_SRC, 8'h03);
    wr(scg_pkg::REG_WAKE_EN, 8'h02);
    cmd(1'b0);
    chk("btParked", btRun, 1'b0);
    chk("watchParked", watchRun, 1'b1);
    wake(1, 1'b0, 0, 0);
    // interval flag keeps coming in light standby
    wr(scg_pkg::REG_SYS_SRC, 8'h00);
    wr(scg_pkg::REG_WAKE_EN, 8'h00);
    wr(scg_pkg::REG_MASK, 8'h08);
    @(posedge clock);
    mainPer <= 8'h01;
    cmd(1'b0);
    n = 0;
    while (intervalFlag !== 1'b1 && n < 9000) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("intervalFlag", intervalFlag, 1'b1);
    @(posedge clock);
    #1;
    chk("irqInterval", irq, 1'b1);
    rd(scg_pkg::REG_STATE, rdv);
    chk("stillHalt", rdv, 8'h05);
    end_of_test;
  end
endmodule

// ---- hdl/scg_bt_if.sv ----
// link between the sequencer and its interval timer
`timescale 1ns/1ps
interface scg_bt_if;
  logic run;
  logic mainTick;
  logic waitStart;
  logic [1:0] waitSel;
  logic intervalTick;
  logic waitDone;
  modport ctrl(output run, mainTick, waitStart, waitSel,
               input intervalTick, waitDone);
  modport timer(input run, mainTick, waitStart, waitSel,
                output intervalTick, waitDone);
endinterface

// ---- hdl/scg_interval_timer.sv ----
// interval timer: reference interval flag and standby wait count
`timescale 1ns/1ps
module scg_interval_timer #(
  parameter int CNT_W = scg_pkg::BT_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // sequencer side
  scg_bt_if.timer bt
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic waiting;
    logic intervalTick;
    logic waitDone;
  } scg_bt_state_t;

  scg_bt_state_t s_ff;
  scg_bt_state_t nxt_s;

  // count main ticks only while allowed to run
  always_comb begin
    nxt_s = s_ff;
    nxt_s.intervalTick = 1'b0;
    nxt_s.waitDone = 1'b0;
    if (bt.waitStart) begin
      nxt_s.cnt = '0; // restart so the wait is whole
      nxt_s.waiting = 1'b1;
    end else if (bt.run && bt.mainTick) begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
      nxt_s.intervalTick = &s_ff.cnt; // flag on wrap
      if (s_ff.waiting &&
          s_ff.cnt == CNT_W'(scg_pkg::waitEnd(bt.waitSel))) begin
        nxt_s.waiting = 1'b0;
        nxt_s.waitDone = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign bt.intervalTick = s_ff.intervalTick;
  assign bt.waitDone = s_ff.waitDone;

  bt_flag_run_a: assert property (@(posedge clock) disable iff (sys_rst)
    s_ff.intervalTick |-> $past(bt.run))
    else $error("interval flag set while timer stopped");
endmodule

// ---- hdl/scg_pkg.sv ----
// constants and types shared by the standby clock gating control block
package scg_pkg;
  // register port
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] REG_CPU_DIV = 3'h0;
  localparam logic [2:0] REG_SYS_SRC = 3'h1;
  localparam logic [2:0] REG_PER_SRC = 3'h2;
  localparam logic [2:0] REG_WAKE_EN = 3'h3;
  localparam logic [2:0] REG_WAIT_SEL = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  localparam logic [2:0] REG_MASK = 3'h6;
  localparam logic [2:0] REG_STATE = 3'h7;
  // system source bits
  localparam int SRC_SUB = 0;
  localparam int SRC_MAIN_OFF = 1;
  // peripheral clock source bits
  localparam int PER_EXT_SCK = 0;
  localparam int PER_EXT_EVENT = 1;
  localparam int PER_WATCH_SUB = 2;
  localparam int PER_DISP_SUB = 3;
  // status bits
  localparam int ST_REFUSED = 0;
  localparam int ST_WOKE = 1;
  localparam int ST_WAITED = 2;
  localparam int ST_INTERVAL = 3;
  // wake request bits with a fixed owner
  localparam int IRQ_BT = 0;
  localparam int IRQ_WATCH = 7;
  // reset values
  localparam logic [1:0] RST_CPU_DIV = 2'h0;
  localparam logic [1:0] RST_SYS_SRC = 2'h0;
  localparam logic [3:0] RST_PER_SRC = 4'h0;
  localparam logic [7:0] RST_WAKE_EN = 8'h00;
  localparam logic [1:0] RST_WAIT_SEL = 2'h0;
  localparam logic [3:0] RST_MASK = 4'h0;
  // divider terminal counts: 64, 8, 4 main ticks, 4 sub ticks
  localparam logic [5:0] END_SLOW = 6'h3F;
  localparam logic [5:0] END_MID = 6'h07;
  localparam logic [5:0] END_FAST = 6'h03;
  localparam logic [5:0] END_SUB = 6'h03;
  // wait lengths in main ticks minus one
  localparam int BT_W = 13;
  localparam logic [12:0] WAIT_0 = 13'h0FFF;
  localparam logic [12:0] WAIT_1 = 13'h01FF;
  localparam logic [12:0] WAIT_2 = 13'h007F;
  localparam logic [12:0] WAIT_3 = 13'h001F;

  typedef enum logic [1:0] {M_RUN, M_HALT, M_STOP, M_WAIT} scg_mode_t;

  function automatic logic [5:0] divEnd(input logic [1:0] sel);
    case (sel)
      2'h0: divEnd = END_SLOW;
      2'h1: divEnd = END_MID;
      default: divEnd = END_FAST;
    endcase
  endfunction

  function automatic logic [12:0] waitEnd(input logic [1:0] sel);
    case (sel)
      2'h0: waitEnd = WAIT_0;
      2'h1: waitEnd = WAIT_1;
      2'h2: waitEnd = WAIT_2;
      default: waitEnd = WAIT_3;
    endcase
  endfunction
endpackage

// ---- hdl/scg_standby_ctrl.sv ----
// standby and cpu clock gating sequencer with its register port
`timescale 1ns/1ps
module scg_standby_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic [scg_pkg::ADDR_W-1:0] regAddr,
  input wire logic [scg_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [scg_pkg::DATA_W-1:0] regRdData,
  // oscillator tick enables
  input wire logic mainTick,
  input wire logic subTick,
  // core side
  input wire logic haltCmd,
  input wire logic stopCmd,
  input wire logic masterEnable,
  input wire logic [7:0] irqReq,
  output logic cpuTick,
  output logic resumeNext,
  output logic resumeVector,
  // oscillator and peripheral gating
  output logic mainOscEn,
  output logic btRun,
  output logic serialRun,
  output logic eventRun,
  output logic watchRun,
  output logic dispRun,
  output logic syncIntRun,
  output logic asyncIntRun,
  output logic intervalFlag,
  // interrupt
  output logic irq
);
  typedef struct packed {
    scg_pkg::scg_mode_t mode;
    logic [1:0] divSel;
    logic [1:0] sysSrc;
    logic [3:0] perSrc;
    logic [7:0] wakeEn;
    logic [1:0] waitSel;
    logic [3:0] status;
    logic [3:0] mask;
    logic [7:0] rdData;
    logic [5:0] divCnt;
    logic waitStart;
    logic cpuTick;
    logic resumeNext;
    logic resumeVector;
    logic mainOscEn;
    logic btRun;
    logic serialRun;
    logic eventRun;
    logic watchRun;
    logic dispRun;
    logic syncIntRun;
    logic asyncIntRun;
    logic intervalFlag;
    logic irq;
  } scg_state_t;

  scg_state_t s_ff;
  scg_state_t nxt_s;
  logic [7:0] reqAll;
  logic wake;
  logic [3:0] sets;
  logic [3:0] kept;
  logic tickSrc;
  logic [5:0] divLast;
  logic mainLive;

  scg_bt_if bt();

  scg_interval_timer #(
    .CNT_W(scg_pkg::BT_W)
  ) u_timer (
    .clock(clock),
    .sys_rst(sys_rst),
    .bt(bt)
  );

  // timer run, start and select come from registered state; main tick goes straight in
  assign bt.run = s_ff.btRun;
  assign bt.mainTick = mainTick;
  assign bt.waitStart = s_ff.waitStart;
  assign bt.waitSel = s_ff.waitSel;

  // own interval flag joins the wake sources
  always_comb begin
    reqAll = irqReq;
    reqAll[scg_pkg::IRQ_BT] = irqReq[scg_pkg::IRQ_BT] | bt.intervalTick;
    wake = |(reqAll & s_ff.wakeEn); // watch bit included
  end

  // divider source and terminal count
  always_comb begin
    tickSrc = s_ff.sysSrc[scg_pkg::SRC_SUB] ? subTick : mainTick;
    divLast = s_ff.sysSrc[scg_pkg::SRC_SUB] ? scg_pkg::END_SUB
                                            : scg_pkg::divEnd(s_ff.divSel);
  end

  // next state: registers, sequencer, gating
  always_comb begin
    nxt_s = s_ff;
    sets = '0;
    // main clock only truly gone when parked while on the sub clock
    mainLive = !(s_ff.sysSrc[scg_pkg::SRC_SUB] &&
                 s_ff.sysSrc[scg_pkg::SRC_MAIN_OFF]);
    nxt_s.waitStart = 1'b0;
    nxt_s.cpuTick = 1'b0;
    nxt_s.resumeNext = 1'b0;
    nxt_s.resumeVector = 1'b0;
    nxt_s.intervalFlag = bt.intervalTick;
    if (bt.intervalTick) begin
      sets[scg_pkg::ST_INTERVAL] = 1'b1;
    end

    // software writes
    if (regWrEn) begin
      case (regAddr)
        scg_pkg::REG_CPU_DIV: nxt_s.divSel = regWrData[1:0];
        scg_pkg::REG_SYS_SRC: nxt_s.sysSrc = regWrData[1:0];
        scg_pkg::REG_PER_SRC: nxt_s.perSrc = regWrData[3:0];
        scg_pkg::REG_WAKE_EN: nxt_s.wakeEn = regWrData;
        scg_pkg::REG_WAIT_SEL: nxt_s.waitSel = regWrData[1:0];
        scg_pkg::REG_MASK: nxt_s.mask = regWrData[3:0];
        default: ;
      endcase
    end

    // read data stands one cycle after the strobe
    nxt_s.rdData = '0;
    kept = s_ff.status;
    if (regRdEn) begin
      case (regAddr)
        scg_pkg::REG_CPU_DIV: nxt_s.rdData = {6'h00, s_ff.divSel};
        scg_pkg::REG_SYS_SRC: nxt_s.rdData = {6'h00, s_ff.sysSrc};
        scg_pkg::REG_PER_SRC: nxt_s.rdData = {4'h0, s_ff.perSrc};
        scg_pkg::REG_WAKE_EN: nxt_s.rdData = s_ff.wakeEn;
        scg_pkg::REG_WAIT_SEL: nxt_s.rdData = {6'h00, s_ff.waitSel};
        scg_pkg::REG_STATUS: begin
          nxt_s.rdData = {4'h0, s_ff.status};
          kept = '0; // read clears
        end
        scg_pkg::REG_MASK: nxt_s.rdData = {4'h0, s_ff.mask};
        scg_pkg::REG_STATE: begin
          nxt_s.rdData = {4'h0, s_ff.sysSrc[scg_pkg::SRC_SUB],
                          s_ff.mainOscEn, 2'(s_ff.mode)};
        end
        default: nxt_s.rdData = '0;
      endcase
    end

    // mode sequencer
    case (s_ff.mode)
      scg_pkg::M_RUN: begin
        // cpu clock divides main or sub ticks
        if (tickSrc) begin
          if (s_ff.divCnt >= divLast) begin
            nxt_s.divCnt = '0;
            nxt_s.cpuTick = 1'b1;
          end else begin
            nxt_s.divCnt = s_ff.divCnt + 6'h01;
          end
        end
        if (stopCmd) begin
          if (s_ff.sysSrc[scg_pkg::SRC_SUB]) begin
            sets[scg_pkg::ST_REFUSED] = 1'b1; // stays running
          end else begin
            nxt_s.mode = scg_pkg::M_STOP;
            nxt_s.cpuTick = 1'b0; // no last tick leaks into standby
          end
        end else if (haltCmd) begin
          nxt_s.mode = scg_pkg::M_HALT; // from either source
          // a tick due now would land in the first halt cycle
          nxt_s.cpuTick = 1'b0;
        end
      end
      scg_pkg::M_HALT, scg_pkg::M_STOP: begin
        nxt_s.divCnt = '0;
        if (wake) begin
          sets[scg_pkg::ST_WOKE] = 1'b1;
          if (mainLive) begin
            // either standby waits here: oscillator restarts after deep standby, timer times the settle
            nxt_s.mode = scg_pkg::M_WAIT;
            nxt_s.waitStart = 1'b1;
          end else begin
            // no main clock to time against, resume at once
            nxt_s.mode = scg_pkg::M_RUN;
            nxt_s.resumeVector = masterEnable;
            nxt_s.resumeNext = !masterEnable;
          end
        end
      end
      scg_pkg::M_WAIT: begin
        if (bt.waitDone) begin
          sets[scg_pkg::ST_WAITED] = 1'b1;
          nxt_s.mode = scg_pkg::M_RUN;
          nxt_s.resumeVector = masterEnable;
          nxt_s.resumeNext = !masterEnable;
        end
      end
      default: nxt_s.mode = scg_pkg::M_RUN;
    endcase

    // a set in the clearing cycle survives
    nxt_s.status = sets | kept;

    // oscillator: off only in deep standby or when software parks it
    nxt_s.mainOscEn = (nxt_s.mode != scg_pkg::M_STOP) &&
      !(nxt_s.sysSrc[scg_pkg::SRC_SUB] &&
        nxt_s.sysSrc[scg_pkg::SRC_MAIN_OFF]);

    // peripheral gating follows the coming mode so it lines up with it
    nxt_s.btRun = nxt_s.mainOscEn; // off in stop
    case (nxt_s.mode)
      scg_pkg::M_STOP: begin
        nxt_s.serialRun = nxt_s.perSrc[scg_pkg::PER_EXT_SCK];
        nxt_s.eventRun = nxt_s.perSrc[scg_pkg::PER_EXT_EVENT];
        nxt_s.watchRun = nxt_s.perSrc[scg_pkg::PER_WATCH_SUB];
        nxt_s.dispRun = nxt_s.perSrc[scg_pkg::PER_DISP_SUB];
      end
      default: begin
        // halt gates only the cpu clock and the synchronised input
        nxt_s.serialRun = nxt_s.mainOscEn;
        nxt_s.eventRun = nxt_s.mainOscEn;
        nxt_s.watchRun = 1'b1;
        nxt_s.dispRun = 1'b1;
      end
    endcase
    // synchronised input needs the cpu clock, so only in run
    nxt_s.syncIntRun = (nxt_s.mode == scg_pkg::M_RUN);
    nxt_s.asyncIntRun = 1'b1;
    nxt_s.irq = |(nxt_s.status & nxt_s.mask);
  end

  // single state register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_ff <= '0;
      s_ff.mode <= scg_pkg::M_RUN;
      s_ff.divSel <= scg_pkg::RST_CPU_DIV;
      s_ff.sysSrc <= scg_pkg::RST_SYS_SRC;
      s_ff.perSrc <= scg_pkg::RST_PER_SRC;
      s_ff.wakeEn <= scg_pkg::RST_WAKE_EN;
      s_ff.waitSel <= scg_pkg::RST_WAIT_SEL;
      s_ff.mask <= scg_pkg::RST_MASK;
      s_ff.mainOscEn <= 1'b1;
      s_ff.btRun <= 1'b1;
      s_ff.serialRun <= 1'b1;
      s_ff.eventRun <= 1'b1;
      s_ff.watchRun <= 1'b1;
      s_ff.dispRun <= 1'b1;
      s_ff.syncIntRun <= 1'b1;
      s_ff.asyncIntRun <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from the state register
  assign regRdData = s_ff.rdData;
  assign cpuTick = s_ff.cpuTick;
  assign resumeNext = s_ff.resumeNext;
  assign resumeVector = s_ff.resumeVector;
  assign mainOscEn = s_ff.mainOscEn;
  assign btRun = s_ff.btRun;
  assign serialRun = s_ff.serialRun;
  assign eventRun = s_ff.eventRun;
  assign watchRun = s_ff.watchRun;
  assign dispRun = s_ff.dispRun;
  assign syncIntRun = s_ff.syncIntRun;
  assign asyncIntRun = s_ff.asyncIntRun;
  assign intervalFlag = s_ff.intervalFlag;
  assign irq = s_ff.irq;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sub_div_a: assert property (
    s_ff.mode == scg_pkg::M_RUN && cpuTick &&
    s_ff.sysSrc[scg_pkg::SRC_SUB] && !regWrEn && !stopCmd && !haltCmd
    |=> !cpuTick ##1 !cpuTick)
    else $error("sub clock cpu tick too close");
  stop_refuse_a: assert property (
    s_ff.mode == scg_pkg::M_RUN && stopCmd &&
    s_ff.sysSrc[scg_pkg::SRC_SUB]
    |=> s_ff.mode == scg_pkg::M_RUN && s_ff.status[scg_pkg::ST_REFUSED])
    else $error("stop on sub clock not refused");
  halt_entry_a: assert property (
    s_ff.mode == scg_pkg::M_RUN && haltCmd && !stopCmd
    |=> s_ff.mode == scg_pkg::M_HALT)
    else $error("halt not entered");
  stop_osc_a: assert property (
    s_ff.mode == scg_pkg::M_STOP |-> !mainOscEn && watchRun ==
    s_ff.perSrc[scg_pkg::PER_WATCH_SUB])
    else $error("main oscillator running in stop");
  halt_gate_a: assert property (
    s_ff.mode == scg_pkg::M_HALT |-> !cpuTick ##1 !cpuTick)
    else $error("cpu clock runs in halt");
  halt_periph_a: assert property (
    s_ff.mode == scg_pkg::M_HALT
    |-> btRun == mainOscEn && eventRun == mainOscEn &&
        serialRun == mainOscEn)
    else $error("halt peripheral gating wrong");
  stop_periph_a: assert property (
    s_ff.mode == scg_pkg::M_STOP |-> !btRun &&
    serialRun == s_ff.perSrc[scg_pkg::PER_EXT_SCK] &&
    eventRun == s_ff.perSrc[scg_pkg::PER_EXT_EVENT] &&
    dispRun == s_ff.perSrc[scg_pkg::PER_DISP_SUB])
    else $error("stop peripheral gating wrong");
  sync_int_a: assert property (
    s_ff.mode != scg_pkg::M_RUN |-> !syncIntRun && asyncIntRun)
    else $error("sync interrupt live in standby");
  wake_exit_a: assert property (
    (s_ff.mode == scg_pkg::M_HALT || s_ff.mode == scg_pkg::M_STOP) &&
    wake |=> s_ff.mode == scg_pkg::M_WAIT || s_ff.mode == scg_pkg::M_RUN)
    else $error("enabled request did not release standby");
  wait_hold_a: assert property (
    s_ff.mode == scg_pkg::M_WAIT && !bt.waitDone
    |=> s_ff.mode == scg_pkg::M_WAIT && !resumeNext && !resumeVector)
    else $error("core resumed before wait ended");
  resume_kind_a: assert property (
    resumeVector |-> $past(masterEnable) && !resumeNext)
    else $error("vector resume without master enable");
  stop_entry_a: assert property (
    s_ff.mode == scg_pkg::M_RUN && stopCmd &&
    !s_ff.sysSrc[scg_pkg::SRC_SUB] |=> s_ff.mode == scg_pkg::M_STOP)
    else $error("stop on main clock not entered");
  bt_stop_a: assert property (
    s_ff.mode == scg_pkg::M_STOP |=> !bt.intervalTick)
    else $error("interval flag set in deep standby");
  halt_bt_a: assert property (
    s_ff.mode == scg_pkg::M_HALT && !btRun |=> !bt.intervalTick)
    else $error("interval timer counted without main clock");
  halt_watch_a: assert property (
    s_ff.mode == scg_pkg::M_HALT |-> watchRun && dispRun)
    else $error("watch or display stopped in halt");
  watch_wake_a: assert property (
    s_ff.mode == scg_pkg::M_STOP && irqReq[scg_pkg::IRQ_WATCH] &&
    s_ff.wakeEn[scg_pkg::IRQ_WATCH] |=> s_ff.mode != scg_pkg::M_STOP)
    else $error("watch flag did not release deep standby");
  wait_osc_a: assert property (
    s_ff.mode == scg_pkg::M_WAIT |-> mainOscEn && btRun)
    else $error("oscillator or timer off during wait");

  stop_wake_c: cover property (
    s_ff.mode == scg_pkg::M_STOP ##1 s_ff.mode == scg_pkg::M_WAIT);
  halt_wake_c: cover property (s_ff.mode == scg_pkg::M_HALT && wake);
  refuse_c: cover property (sets[scg_pkg::ST_REFUSED]);
  vector_c: cover property (resumeVector);
  park_wake_c: cover property (resumeNext && !mainOscEn);
endmodule
